// >>> src/sdpb_mem.sv
`timescale 1ns/1ps
// How it works
// - Controller waits for all banks closed and timers idle, then powers down.
// - Low clock enable ignores every command input.
// - Controller leaves power-down before refresh period ends.
// - Clock enable changes act one cycle later.
// - Address bit ten on access requests auto-precharge.
// - Read auto-precharge starts CL-1 before last data.
// - Write auto-precharge starts write recovery after data.
// - Row and write strobes low start precharge.
// - Address bit ten chooses one bank or all.
// - Read precharge no earlier than CL-1 before end.
// - Write precharge waits write recovery after data.
// - Access, burst stop, or precharge of the burst's bank or of all banks cut bursts.
// - Controller avoids both ends driving data together.
// - Burst stop discards the remaining write data.
// - Words before burst stop are still written.
module sdpb_mem (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_cl3,
    sdpb_if.mem bus,
    output logic o_power_down,
    output logic [sdpb_pkg::BANKS-1:0] o_bank_open,
    output logic [sdpb_pkg::BANKS-1:0] o_bank_precharging
);
    import sdpb_pkg::*;

    function automatic sdpb_cnt_t cnt_dec(input sdpb_cnt_t c);
        cnt_dec = (c == CNT_ZERO) ? CNT_ZERO : c - CNT_ONE;
    endfunction

    // Sequential burst order wraps inside the burst-aligned block of columns.
    function automatic logic [COL_W-1:0] col_next(input logic [COL_W-1:0] c);
        col_next = {c[COL_W-1:BL_W], c[BL_W-1:0] + 1'b1};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode.
    logic pd_q;
    logic [BANKS-1:0] open_q;
    sdpb_cnt_t pcnt_q [BANKS];

    wire clk_on = ~pd_q;
    wire [3:0] cmd_bits = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
    wire ap_bit = bus.addr[AP_BIT];
    wire [BA_W-1:0] cmd_bank = bus.ba;
    wire [COL_W-1:0] cmd_col = bus.addr[COL_W-1:0];
    wire cmd_bank_open = open_q[cmd_bank];

    wire is_act = clk_on && (cmd_bits == CMD_ACT);
    wire is_rd = clk_on && (cmd_bits == CMD_RD) && cmd_bank_open;
    wire is_wr = clk_on && (cmd_bits == CMD_WR) && cmd_bank_open;
    wire is_pre = clk_on && (cmd_bits == CMD_PRE);
    wire is_bst = clk_on && (cmd_bits == CMD_BST);

    ////////////////////////////////////////////////////////////////////////////////
    // Burst engine.
    logic rd_q;
    logic wr_q;
    logic ap_q;
    logic [BA_W-1:0] bb_q;
    logic [COL_W-1:0] col_q;
    sdpb_cnt_t left_q;
    logic rd_ap_q;
    sdpb_cnt_t wrec_q;
    logic [BA_W-1:0] apb_q;

    wire busy = rd_q || wr_q;
    wire last = busy && (left_q == CNT_ONE);
    wire hit_pre = is_pre && (ap_bit || (cmd_bank == bb_q));
    wire start = is_rd || is_wr;
    wire stop = busy && (is_bst || hit_pre);
    wire step = busy && !start && !stop;
    wire rd_end_ap = step && last && rd_q && ap_q;
    wire wr_end_ap = step && last && wr_q && ap_q;
    wire wr_close = (wrec_q == CNT_ONE);
    wire ap_go = rd_ap_q || wr_close;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            ap_q <= 1'b0;
            bb_q <= '0;
            col_q <= '0;
            left_q <= CNT_ZERO;
        end else if (start) begin
            rd_q <= is_rd;
            wr_q <= is_wr;
            ap_q <= ap_bit;
            bb_q <= cmd_bank;
            col_q <= col_next(cmd_col);
            left_q <= BL_LAST;
        end else if (stop) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            ap_q <= 1'b0;
        end else if (step) begin
            col_q <= col_next(col_q);
            left_q <= cnt_dec(left_q);
            if (last) begin
                rd_q <= 1'b0;
                wr_q <= 1'b0;
                ap_q <= 1'b0;
            end
        end
    end

    // The read precharge fires on the edge after the last internal fetch; that edge
    // lies CL-1 cycles ahead of the last word on the pins for either latency.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_ap_q <= 1'b0;
            wrec_q <= CNT_ZERO;
            apb_q <= '0;
        end else begin
            rd_ap_q <= rd_end_ap;
            if (wr_end_ap) begin
                wrec_q <= WR_CNT;
            end else begin
                wrec_q <= cnt_dec(wrec_q);
            end
            if (rd_end_ap || wr_end_ap) begin
                apb_q <= bb_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bank state and precharge timing.
    logic [BANKS-1:0] close_b;
    logic [BANKS-1:0] act_b;

    always_comb begin
        for (int b = 0; b < BANKS; b++) begin
            close_b[b] = (is_pre && (ap_bit || (cmd_bank == BA_W'(b))))
                || (ap_go && (apb_q == BA_W'(b)));
            // The precharge period is over at the edge where the counter leaves one.
            act_b[b] = is_act && (cmd_bank == BA_W'(b)) && (cnt_dec(pcnt_q[b]) == CNT_ZERO);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            open_q <= '0;
            for (int b = 0; b < BANKS; b++) begin
                pcnt_q[b] <= CNT_ZERO;
            end
        end else begin
            for (int b = 0; b < BANKS; b++) begin
                if (close_b[b]) begin
                    open_q[b] <= 1'b0;
                    pcnt_q[b] <= RP_CNT;
                end else begin
                    pcnt_q[b] <= cnt_dec(pcnt_q[b]);
                    if (act_b[b]) begin
                        open_q[b] <= 1'b1;
                    end
                end
            end
        end
    end

    always_comb begin
        for (int b = 0; b < BANKS; b++) begin
            o_bank_precharging[b] = (pcnt_q[b] != CNT_ZERO);
        end
    end

    assign o_bank_open = open_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Array access. Write data at a burst stop edge is dropped, earlier words land.
    logic [DQ_W-1:0] array_q [2**(BA_W+COL_W)];
    logic [DQ_W-1:0] pdat_q [RD_PIPE];
    logic [RD_PIPE-1:0] pval_q;

    wire wr_now = is_wr || (step && wr_q);
    wire rd_now = is_rd || (step && rd_q);
    wire [BA_W+COL_W-1:0] acc_idx = start ? {cmd_bank, cmd_col} : {bb_q, col_q};

    always_ff @(posedge i_ref_clk) begin
        if (wr_now) begin
            array_q[acc_idx] <= bus.ctrl_dq;
        end
        pdat_q[0] <= array_q[acc_idx];
        for (int s = 1; s < RD_PIPE; s++) begin
            pdat_q[s] <= pdat_q[s-1];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pval_q <= '0;
        end else begin
            pval_q <= {pval_q[RD_PIPE-2:0], rd_now};
        end
    end

    // Words already fetched still leave the pipe after a stop or precharge.
    wire [1:0] out_stage = i_cl3 ? 2'(CL3_STAGE) : 2'(CL2_STAGE);
    assign bus.mem_dq = pdat_q[out_stage];
    assign bus.mem_dq_oe = pval_q[out_stage];

    ////////////////////////////////////////////////////////////////////////////////
    // Power-down: clock enable is taken one edge late, so entry and exit each
    // take effect one cycle after the pin moves.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= ~bus.cke;
        end
    end

    assign o_power_down = pd_q;
endmodule

// >>> src/sdpb_pkg.sv
package sdpb_pkg;
    localparam int DQ_W = 16;
    localparam int ADDR_W = 11;
    localparam int BANKS = 2;
    localparam int BA_W = 1;
    localparam int AP_BIT = 10;
    localparam int COL_W = 7;
    localparam int BL_W = 2;
    localparam int CNT_W = 4;
    localparam int REF_W = 24;
    localparam int RD_PIPE = 3;
    localparam int CL2_STAGE = 1;
    localparam int CL3_STAGE = 2;

    localparam int CLK_MHZ = 200;
    localparam int T_RP_NS = 15;
    localparam int T_WR_NS = 10;
    localparam int T_REF_MS = 64;
    localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int WR_CYC = (T_WR_NS * CLK_MHZ + 999) / 1000;
    localparam int REF_CYC = T_REF_MS * CLK_MHZ * 1000;
    localparam int BURST_LEN = 4;
    localparam int CAS_LAT2 = 2;
    localparam int CAS_LAT3 = 3;

    typedef logic [CNT_W-1:0] sdpb_cnt_t;
    localparam sdpb_cnt_t CNT_ZERO = 4'h0;
    localparam sdpb_cnt_t CNT_ONE = 4'h1;
    localparam sdpb_cnt_t BL_LAST = CNT_W'(BURST_LEN - 1);
    localparam sdpb_cnt_t RP_CNT = CNT_W'(RP_CYC);
    localparam sdpb_cnt_t WR_CNT = CNT_W'(WR_CYC);
    localparam sdpb_cnt_t RP_GAP = CNT_W'(RP_CYC - 1);
    localparam sdpb_cnt_t RD_PRE_GAP = CNT_W'(BURST_LEN - 1);
    localparam sdpb_cnt_t WR_PRE_GAP = CNT_W'(BURST_LEN - 2 + WR_CYC);
    localparam sdpb_cnt_t RDAP_GAP = CNT_W'(BURST_LEN + RP_CYC - 1);
    localparam sdpb_cnt_t WRAP_GAP = CNT_W'(BURST_LEN - 2 + WR_CYC + RP_CYC);
    localparam sdpb_cnt_t BUS_GAP2 = CNT_W'(CAS_LAT2 + BURST_LEN - 1);
    localparam sdpb_cnt_t BUS_GAP3 = CNT_W'(CAS_LAT3 + BURST_LEN - 1);

    // Pin order is {cs_n, ras_n, cas_n, we_n}.
    typedef enum logic [3:0] {
        CMD_PRE = 4'h2,
        CMD_ACT = 4'h3,
        CMD_WR = 4'h4,
        CMD_RD = 4'h5,
        CMD_BST = 4'h6,
        CMD_NOP = 4'h7,
        CMD_DESEL = 4'hF
    } sdpb_cmd_e;

    typedef enum logic [2:0] {
        REQ_ACT = 3'h0,
        REQ_RD = 3'h1,
        REQ_WR = 3'h2,
        REQ_PRE = 3'h3,
        REQ_BST = 3'h4,
        REQ_PD_ENTER = 3'h5,
        REQ_PD_EXIT = 3'h6
    } sdpb_req_e;
endpackage

// >>> src/sdpb_if.sv
`timescale 1ns/1ps
interface sdpb_if;
    import sdpb_pkg::*;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [BA_W-1:0] ba;
    logic [DQ_W-1:0] ctrl_dq;
    logic ctrl_dq_oe;
    logic [DQ_W-1:0] mem_dq;
    logic mem_dq_oe;

    modport mem (
        input cke, cs_n, ras_n, cas_n, we_n, addr, ba, ctrl_dq, ctrl_dq_oe,
        output mem_dq, mem_dq_oe
    );
    modport ctrl (
        output cke, cs_n, ras_n, cas_n, we_n, addr, ba, ctrl_dq, ctrl_dq_oe,
        input mem_dq, mem_dq_oe
    );
endinterface

// >>> src/sdpb_ctrl.sv
`timescale 1ns/1ps
module sdpb_ctrl #(
    parameter int REF_LIMIT = sdpb_pkg::REF_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_cl3,
    input wire logic i_req_valid,
    input wire sdpb_pkg::sdpb_req_e i_req_kind,
    input wire logic [sdpb_pkg::BA_W-1:0] i_req_bank,
    input wire logic [sdpb_pkg::ADDR_W-1:0] i_req_addr,
    output logic o_req_ready,
    input wire logic [sdpb_pkg::DQ_W-1:0] i_wr_data,
    output logic o_wr_take,
    output logic [sdpb_pkg::DQ_W-1:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_power_down,
    sdpb_if.ctrl bus
);
    import sdpb_pkg::*;

    function automatic sdpb_cnt_t cnt_dec(input sdpb_cnt_t c);
        cnt_dec = (c == CNT_ZERO) ? CNT_ZERO : c - CNT_ONE;
    endfunction

    function automatic sdpb_cnt_t cnt_max(input sdpb_cnt_t a, input sdpb_cnt_t b);
        cnt_max = (a > b) ? a : b;
    endfunction

    function automatic logic [3:0] enc(input sdpb_req_e k);
        case (k)
            REQ_ACT: enc = CMD_ACT;
            REQ_RD: enc = CMD_RD;
            REQ_WR: enc = CMD_WR;
            REQ_PRE: enc = CMD_PRE;
            REQ_BST: enc = CMD_BST;
            default: enc = CMD_NOP;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic cke_q;
    logic [3:0] cmd_q;
    logic [ADDR_W-1:0] addr_q;
    logic [BA_W-1:0] ba_q;
    logic [DQ_W-1:0] dq_q;
    logic dq_oe_q;
    logic [BANKS-1:0] open_q;
    sdpb_cnt_t idle_q;
    sdpb_cnt_t preg_q;
    sdpb_cnt_t busg_q;
    sdpb_cnt_t wleft_q;
    logic [REF_W-1:0] ref_q;
    logic ok;

    wire pd = ~cke_q;
    wire ap = i_req_addr[AP_BIT];
    wire bank_open = open_q[i_req_bank];
    wire ref_due = pd && (ref_q >= REF_W'(REF_LIMIT - 1));
    wire timers_idle = (idle_q == CNT_ZERO) && (busg_q == CNT_ZERO) && (wleft_q == CNT_ZERO);

    always_comb begin
        case (i_req_kind)
            REQ_ACT: ok = !bank_open && (idle_q == CNT_ZERO);
            REQ_RD: ok = bank_open;
            REQ_WR: ok = bank_open && (busg_q == CNT_ZERO);
            REQ_PRE: ok = (preg_q == CNT_ZERO);
            REQ_BST: ok = 1'b1;
            REQ_PD_ENTER: ok = (open_q == '0) && timers_idle;
            default: ok = 1'b0;
        endcase
    end

    assign o_req_ready = (i_req_kind == REQ_PD_EXIT) ? pd : (!pd && ok);
    wire take = i_req_valid && o_req_ready;
    wire take_rd = take && (i_req_kind == REQ_RD);
    wire take_wr = take && (i_req_kind == REQ_WR);
    wire take_pre = take && (i_req_kind == REQ_PRE);
    wire take_cut = take_rd || take_pre || (take && (i_req_kind == REQ_BST));
    wire exit_now = pd && (ref_due || (take && (i_req_kind == REQ_PD_EXIT)));
    wire wr_beat = take_wr || ((wleft_q != CNT_ZERO) && !take_cut);
    assign o_wr_take = wr_beat;
    wire [3:0] cmd_d = take ? enc(i_req_kind) : CMD_NOP;
    wire sdpb_cnt_t bus_gap = i_cl3 ? BUS_GAP3 : BUS_GAP2;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cke_q <= 1'b1;
            cmd_q <= CMD_NOP;
            addr_q <= '0;
            ba_q <= '0;
            dq_q <= '0;
            dq_oe_q <= 1'b0;
            ref_q <= '0;
            o_rd_data <= '0;
            o_rd_valid <= 1'b0;
        end else begin
            if (take && (i_req_kind == REQ_PD_ENTER)) begin
                cke_q <= 1'b0;
            end else if (exit_now) begin
                cke_q <= 1'b1;
            end
            cmd_q <= cmd_d;
            if (take) begin
                addr_q <= i_req_addr;
                ba_q <= i_req_bank;
            end
            dq_oe_q <= wr_beat;
            if (wr_beat) begin
                dq_q <= i_wr_data;
            end
            ref_q <= pd ? ref_q + 1'b1 : '0;
            o_rd_valid <= bus.mem_dq_oe;
            o_rd_data <= bus.mem_dq;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            open_q <= '0;
            idle_q <= CNT_ZERO;
            preg_q <= CNT_ZERO;
            busg_q <= CNT_ZERO;
            wleft_q <= CNT_ZERO;
        end else begin
            wleft_q <= take_wr ? BL_LAST : (take_cut ? CNT_ZERO : cnt_dec(wleft_q));
            if (take_rd) begin
                preg_q <= cnt_max(cnt_dec(preg_q), RD_PRE_GAP);
                busg_q <= cnt_max(cnt_dec(busg_q), bus_gap);
                idle_q <= ap ? cnt_max(cnt_dec(idle_q), RDAP_GAP) : cnt_dec(idle_q);
            end else if (take_wr) begin
                preg_q <= cnt_max(cnt_dec(preg_q), WR_PRE_GAP);
                busg_q <= cnt_dec(busg_q);
                idle_q <= ap ? cnt_max(cnt_dec(idle_q), WRAP_GAP) : cnt_dec(idle_q);
            end else if (take_pre) begin
                preg_q <= cnt_dec(preg_q);
                busg_q <= cnt_dec(busg_q);
                idle_q <= cnt_max(cnt_dec(idle_q), RP_GAP);
            end else begin
                preg_q <= cnt_dec(preg_q);
                busg_q <= cnt_dec(busg_q);
                idle_q <= cnt_dec(idle_q);
            end
            if (take && (i_req_kind == REQ_ACT)) begin
                open_q[i_req_bank] <= 1'b1;
            end else if ((take_rd || take_wr) && ap) begin
                open_q[i_req_bank] <= 1'b0;
            end else if (take_pre) begin
                if (ap) begin
                    open_q <= '0;
                end else begin
                    open_q[i_req_bank] <= 1'b0;
                end
            end
        end
    end

    assign o_power_down = pd;
    assign bus.cke = cke_q;
    assign bus.cs_n = cmd_q[3];
    assign bus.ras_n = cmd_q[2];
    assign bus.cas_n = cmd_q[1];
    assign bus.we_n = cmd_q[0];
    assign bus.addr = addr_q;
    assign bus.ba = ba_q;
    assign bus.ctrl_dq = dq_q;
    assign bus.ctrl_dq_oe = dq_oe_q;
endmodule

// >>> verification/sdpb_monitor.sv
`timescale 1ns/1ps
module sdpb_monitor (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_cl3,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic ctrl_dq_oe,
    input wire logic mem_dq_oe
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    wire nop = !cs_n && ras_n && cas_n && we_n;
    wire rd_cmd = cke && !cs_n && ras_n && !cas_n && we_n;
    wire wr_cmd = cke && !cs_n && ras_n && !cas_n && !we_n;
    wire pre_cmd = cke && !cs_n && !ras_n && cas_n && !we_n;
    wire bst_cmd = cke && !cs_n && ras_n && cas_n && !we_n;
    wire no_cut = !pre_cmd && !bst_cmd && !rd_cmd && !wr_cmd;
    sequence wr_uncut;
        wr_cmd ##1 no_cut [*3];
    endsequence
    sequence rd_held;
        rd_cmd ##1 no_cut;
    endsequence
    sequence pd_held;
        !cke ##1 !cke;
    endsequence
    a_no_bus_fight: assert property (!(ctrl_dq_oe && mem_dq_oe))
        else $error("both ends drive data");
    a_write_burst_len: assert property (wr_uncut |-> ctrl_dq_oe && $past(ctrl_dq_oe, 2))
        else $error("write burst shorter than four words");
    a_write_recovery: assert property (wr_uncut |=> (!pre_cmd && !ctrl_dq_oe) || wr_cmd)
        else $error("precharge or data inside write recovery");
    a_stop_drops_wr: assert property (bst_cmd |=> !ctrl_dq_oe || wr_cmd)
        else $error("write data after burst stop");
    a_read_cas_lat: assert property (rd_held |-> ##1 (i_cl3 || mem_dq_oe) ##1 mem_dq_oe)
        else $error("read data late for latency");
    a_read_pre_gap: assert property (rd_cmd |=> !pre_cmd [*2])
        else $error("precharge too early in read burst");
    a_pd_enter_nop: assert property ($fell(cke) |-> nop && !ctrl_dq_oe)
        else $error("command at power-down entry");
    a_pd_exit_nop: assert property ($rose(cke) |-> nop)
        else $error("command at power-down exit");
    a_pd_quiet_pins: assert property (pd_held |-> !ctrl_dq_oe && !mem_dq_oe && (nop || cs_n))
        else $error("activity in power-down");
    a_pd_after_pre: assert property ($fell(cke) |-> !$past(pre_cmd, 1) && !$past(pre_cmd, 2))
        else $error("power-down inside precharge time");
endmodule

// >>> verification/sdram_precharge_powerdown_burst_stop_tb.sv
`timescale 1ns/1ps
module sdram_precharge_powerdown_burst_stop_tb;
    import sdpb_pkg::*;
    localparam int REF_SIM = 50;
    logic i_ref_clk = 1'h0;
    logic i_rst_n = 1'h0;
    logic i_cl3 = 1'h0;
    logic i_req_valid = 1'h0;
    sdpb_req_e i_req_kind = REQ_ACT;
    logic [BA_W-1:0] i_req_bank = '0;
    logic [ADDR_W-1:0] i_req_addr = '0;
    logic [DQ_W-1:0] i_wr_data = '0;
    logic o_req_ready, o_wr_take, o_rd_valid, c_pd, m_pd, b_pd;
    logic [DQ_W-1:0] o_rd_data;
    logic [BANKS-1:0] m_open, m_prech, b_open;
    logic [DQ_W-1:0] model [256];
    logic [DQ_W-1:0] wd [4];
    logic [DQ_W-1:0] rq [$];
    int mismatches = 0;
    int num_checks = 0;
    int wk = 0;
    int seed = 32'h212b_e540;
    sdpb_if bus ();
    sdpb_if bus_b ();
    sdpb_ctrl #(.REF_LIMIT(REF_SIM)) i_sdpb_ctrl (.i_ref_clk, .i_rst_n, .i_cl3, .i_req_valid,
        .i_req_kind, .i_req_bank, .i_req_addr, .o_req_ready, .i_wr_data, .o_wr_take,
        .o_rd_data, .o_rd_valid, .o_power_down(c_pd), .bus(bus));
    sdpb_mem i_sdpb_mem (.i_ref_clk, .i_rst_n, .i_cl3, .bus(bus), .o_power_down(m_pd),
        .o_bank_open(m_open), .o_bank_precharging(m_prech));
    // Second device driven directly by the bench, breaking the power-down pin rules.
    sdpb_mem i_sdpb_mem_b (.i_ref_clk, .i_rst_n, .i_cl3, .bus(bus_b), .o_power_down(b_pd),
        .o_bank_open(b_open), .o_bank_precharging());
    sdpb_monitor i_sdpb_monitor (.i_ref_clk, .i_rst_n, .i_cl3, .cke(bus.cke), .cs_n(bus.cs_n),
        .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .ctrl_dq_oe(bus.ctrl_dq_oe),
        .mem_dq_oe(bus.mem_dq_oe));
    initial begin
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s: expected %0h, seen %0h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    // Returns one and a half cycles after the take edge, with valid already low.
    task automatic req(input sdpb_req_e k, input int b, input int a);
        int n = 0;
        i_req_kind = k;
        i_req_bank = b[BA_W-1:0];
        i_req_addr = a[ADDR_W-1:0];
        i_req_valid = 1'h1;
        #1;
        while (o_req_ready !== 1'h1 && n < 300) begin
            cyc(1);
            #1;
            n++;
        end
        chk("request ready", n < 300, 1);
        cyc(1);
        i_req_valid = 1'h0;
        cyc(1);
    endtask
    function automatic int ix(int b, int c, int k);
        return (b << 7) + (c & 8'h7c) + ((c + k) & 2'h3);
    endfunction
    task automatic wr(input int b, input int c, input int ap, input int lim);
        for (int k = 0; k < 4; k++) begin
            wd[k] = $random(seed);
            if (k < lim) model[ix(b, c, k)] = wd[k];
        end
        wk = 0;
        cyc(1);
        req(REQ_WR, b, (ap << AP_BIT) | c);
    endtask
    task automatic rd(input int b, input int c, input int ap);
        for (int k = 0; k < 4; k++) begin
            rq.push_back(model[ix(b, c, k)]);
        end
        req(REQ_RD, b, (ap << AP_BIT) | c);
    endtask
    task automatic pins(input sdpb_cmd_e c, input int a);
        {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n} = c;
        bus_b.addr = a[ADDR_W-1:0];
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_ref_clk) begin
        if (o_wr_take === 1'h1) begin
            wk <= wk + 1;
        end
    end
    always @(negedge i_ref_clk) begin
        i_wr_data <= wd[wk[1:0]];
        if (o_rd_valid === 1'h1) begin
            chk("read expected", rq.size() > 0, 1);
            chk("read word", o_rd_data, rq.size() > 0 ? rq.pop_front() : '0);
        end
    end
    initial begin
        cyc(20000);
        mismatches++;
        close_out();
    end
    initial begin
        int b;
        int c;
        bus_b.ba = '0;
        bus_b.ctrl_dq = '0;
        bus_b.ctrl_dq_oe = 1'h0;
        bus_b.cke = 1'h1;
        pins(CMD_NOP, 0);
        cyc(20);
        i_rst_n = 1'h1;
        cyc(1);
        chk("cke after reset", bus.cke, 1);
        chk("banks after reset", m_open, 0);
        for (int cl = 0; cl < 2; cl++) begin
            i_cl3 = cl[0];
            b = cl;
            c = $random(seed) & 8'h7f;
            req(REQ_ACT, b, c);
            chk("bank opened", m_open[b], 1);
            wr(b, c, 0, 4);
            // A read taken while write words are still due would cut the burst.
            cyc(2);
            rd(b, c, 0);
            cyc(10);
            chk("reads drained", rq.size(), 0);
            chk("bank kept open", m_open[b], 1);
            wr(b, c, 0, 2);
            req(REQ_BST, 0, 0);
            cyc(4);
            chk("words before stop", wk, 2);
            chk("bank open after stop", m_open[b], 1);
            rd(b, c, 0);
            cyc(10);
            chk("reads drained", rq.size(), 0);
            wr(b, c, 1, 4);
            cyc(4);
            chk("write precharge early", m_open[b], 1);
            cyc(1);
            chk("write precharge start", m_open[b], 0);
            req(REQ_ACT, b, c);
            rd(b, c, 1);
            cyc(3);
            chk("read precharge early", m_open[b], 1);
            cyc(1);
            chk("read precharge start", m_open[b], 0);
            cyc(8);
            req(REQ_ACT, b, 0);
            req(REQ_ACT, 1 - b, 0);
            req(REQ_PRE, b, 0);
            chk("single bank precharge", m_open, 1 << (1 - b));
            chk("bank precharging", m_prech[b], 1);
            req(REQ_PRE, 0, 1 << AP_BIT);
            chk("all bank precharge", m_open, 0);
            $display("test burst and precharge cl%0d done", cl + 2);
        end
        cyc(6);
        req(REQ_PD_ENTER, 0, 0);
        chk("controller power down", c_pd, 1);
        chk("device power down", m_pd, 1);
        cyc(5);
        req(REQ_PD_EXIT, 0, 0);
        chk("device awake", m_pd, 0);
        req(REQ_PD_ENTER, 0, 0);
        cyc(REF_SIM - 10);
        chk("held in power down", c_pd, 1);
        cyc(20);
        chk("forced exit", c_pd, 0);
        $display("test power down done");
        pins(CMD_ACT, 0);
        bus_b.cke = 1'h0;
        cyc(1);
        chk("command at entry edge", b_open[0], 1);
        chk("entry after one clock", b_pd, 1);
        pins(CMD_PRE, 1 << AP_BIT);
        cyc(2);
        chk("pins ignored", b_open[0], 1);
        bus_b.cke = 1'h1;
        cyc(1);
        chk("exit after one clock", b_open[0], 1);
        cyc(1);
        chk("precharge after exit", b_open, 0);
        pins(CMD_NOP, 0);
        $display("test pin gating done");
        close_out();
    end
endmodule
